// *** ptr_pkg.sv ***
/*
 * Constants for the program memory table-read unit.
 * Assumes the core decodes table instructions and provides a 16-bit program memory read port.
 */
// Behaviour
// R1: read address is the high and low table pointer bytes combined.
// R2: both table read forms load the fetched upper byte into the high latch.
// R3: software can read and write the table high latch for save and restore.
// R4: every table instruction takes exactly two instruction cycles.
// R5: software avoids table reads in both main and interrupt code, or masks interrupts.
// R6: table memory spans 4K words; last page starts at 0f00.
// R7: lower byte goes to named data register; unused upper bits read zero.
// R8: the extended read form, for other sectors, performs the same fetch.
// R9: each fetched word is 16 bits from a 4K-word array.
// R10: table pointers hold their value across reads; software moves them.
package ptr_pkg;
   localparam int ADDR_W = 12;
   localparam int WORD_W = 16;
   localparam int MEM_WORDS = 4096;
   localparam logic [11:0] LAST_PAGE = 12'hf00;
   localparam logic [7:0] PTR_LOW_RST = 8'h00;
   localparam logic [7:0] PTR_HIGH_RST = 8'h00;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] DEST_RST = 8'h00;
   localparam int TABLE_CYCLES = 2;
   typedef enum logic [0:0] {
      PTR_IDLE = 1'b0,
      PTR_FETCH = 1'b1
   } ptr_state_e;
endpackage

// *** ptr_table_read.sv ***
/*
 * Table-read unit: pointer registers, fetch sequencer, table high latch.
 * Assumes a synchronous program memory returning data one cycle after the address,
 * and that the core issues a new table op only when busy is low.
 */
`timescale 1ns/1ps
module ptr_table_read #(
   parameter int HIGH_BITS = 8
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic tableReadOp,
   input wire logic table_read_extended_op,
   input wire logic [7:0] destAddr,
   input wire logic ptrLowWrite,
   input wire logic table_pointer_highWrite,
   input wire logic latchWrite,
   input wire logic [7:0] wrData,
   output logic [7:0] tablePointerLow,
   output logic [7:0] table_pointer_high,
   output logic [7:0] table_high_latch,
   output logic [11:0] progAddr,
   output logic progRead,
   input wire logic [15:0] progData,
   output logic destWrite,
   output logic [7:0] destWriteAddr,
   output logic [7:0] destWriteData,
   output logic busy
);

   // ***********************************
   // elaboration checks
   // ***********************************

   // latch masking serves one to eight live bits
   if (HIGH_BITS < 1 || HIGH_BITS > 8) begin : g_bad_high_bits
      $error("HIGH_BITS out of range");
   end

   // address port is sized for the 4K-word array
   if (ptr_pkg::ADDR_W != 12 || ptr_pkg::MEM_WORDS != (1 << ptr_pkg::ADDR_W)) begin : g_bad_addr
      $error("program memory size does not match the address port");
   end

   // data port carries 16-bit words
   if (ptr_pkg::WORD_W != 16) begin : g_bad_word
      $error("program word width does not match the data port");
   end

   // sequencer is built for a two-cycle instruction
   if (ptr_pkg::TABLE_CYCLES != 2) begin : g_bad_cycles
      $error("sequencer supports two-cycle table instructions only");
   end

   // last page must sit inside the array
   if (int'(ptr_pkg::LAST_PAGE) >= ptr_pkg::MEM_WORDS) begin : g_bad_page
      $error("last page lies outside the program memory");
   end

   // ***********************************
   // declarations
   // ***********************************

   ptr_pkg::ptr_state_e state;
   ptr_pkg::ptr_state_e next_state;
   logic [7:0] destHold;
   logic [7:0] next_destHold;
   logic [7:0] next_tablePointerLow;
   logic [7:0] next_table_pointer_high;
   logic [7:0] next_table_high_latch;
   logic next_destWrite;
   logic [7:0] next_destWriteAddr;
   logic [7:0] next_destWriteData;
   logic readRequest;
   logic takeRead;
   logic fetchCycle;
   wire logic [7:0] fetchedHigh;

   // ***********************************
   // request decode
   // ***********************************

   // both read forms perform the same fetch [R8]
   assign readRequest = tableReadOp || table_read_extended_op;

   // a request is taken only in the first instruction cycle
   assign takeRead = (state == ptr_pkg::PTR_IDLE) && readRequest;
   assign fetchCycle = (state == ptr_pkg::PTR_FETCH);

   // ***********************************
   // upper byte masking
   // ***********************************

   // unused upper bits of the fetched word read as zero [R7]
   for (genvar i = 0; i < 8; i++) begin : g_high_mask
      if (i < HIGH_BITS) begin : g_live
         assign fetchedHigh[i] = progData[8 + i];
      end else begin : g_dead
         assign fetchedHigh[i] = 1'b0;
      end
   end

   // ***********************************
   // fetch sequencer
   // ***********************************

   always_comb begin
      next_state = state;
      next_destHold = destHold;
      case (state)
         ptr_pkg::PTR_IDLE: begin
            if (readRequest) begin // [R8]
               // destination is sampled with the request
               next_destHold = destAddr;
               next_state = ptr_pkg::PTR_FETCH;
            end
         end
         ptr_pkg::PTR_FETCH: begin
            // second cycle completes the instruction; requests here are ignored [R4]
            next_state = ptr_pkg::PTR_IDLE;
         end
         default: begin
            next_state = ptr_pkg::PTR_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ptr_pkg::PTR_IDLE;
         destHold <= ptr_pkg::DEST_RST;
      end else begin
         state <= next_state;
         destHold <= next_destHold;
      end
   end

   // ***********************************
   // table pointers
   // ***********************************

   always_comb begin
      next_tablePointerLow = tablePointerLow;
      next_table_pointer_high = table_pointer_high;
      // pointers only change on explicit writes, never by a read [R10]
      if (ptrLowWrite) begin
         next_tablePointerLow = wrData;
      end
      // only the four address bits of the high pointer are stored [R6]
      if (table_pointer_highWrite) begin
         next_table_pointer_high = {4'h0, wrData[3:0]};
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tablePointerLow <= ptr_pkg::PTR_LOW_RST;
         table_pointer_high <= ptr_pkg::PTR_HIGH_RST;
      end else begin
         tablePointerLow <= next_tablePointerLow;
         table_pointer_high <= next_table_pointer_high;
      end
   end

   // ***********************************
   // table high latch
   // ***********************************

   always_comb begin
      next_table_high_latch = table_high_latch;
      if (fetchCycle) begin
         // hardware load wins over a software write in the same cycle [R2]
         next_table_high_latch = fetchedHigh;
      end else if (latchWrite) begin
         // software save and restore path [R3]
         next_table_high_latch = wrData;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         table_high_latch <= ptr_pkg::LATCH_RST;
      end else begin
         table_high_latch <= next_table_high_latch;
      end
   end

   // ***********************************
   // destination write
   // ***********************************

   always_comb begin
      next_destWrite = 1'b0;
      next_destWriteAddr = destWriteAddr;
      next_destWriteData = destWriteData;
      if (fetchCycle) begin
         // one-cycle strobe in the cycle after the second instruction cycle [R4]
         next_destWrite = 1'b1;
         next_destWriteAddr = destHold;
         // low byte of the fetched word [R7] [R9]
         next_destWriteData = progData[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         destWrite <= 1'b0;
         destWriteAddr <= ptr_pkg::DEST_RST;
         destWriteData <= ptr_pkg::DEST_RST;
      end else begin
         destWrite <= next_destWrite;
         destWriteAddr <= next_destWriteAddr;
         destWriteData <= next_destWriteData;
      end
   end

   // ***********************************
   // program memory port
   // ***********************************

   // 12-bit word address within the 4K array [R1] [R6] [R9]
   assign progAddr = {table_pointer_high[3:0], tablePointerLow};

   // memory latches the address at the request edge
   assign progRead = takeRead;
   assign busy = fetchCycle;
endmodule

// *** ptr_table_read_chk.sv ***
/* port checker for the table-read unit.
   bound to ptr_table_read from the testbench top file */
`timescale 1ns/1ps
module ptr_table_read_chk #(
   parameter int HIGH_BITS = 8
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic tableReadOp,
   input wire logic table_read_extended_op,
   input wire logic [7:0] destAddr,
   input wire logic ptrLowWrite,
   input wire logic table_pointer_highWrite,
   input wire logic latchWrite,
   input wire logic [7:0] wrData,
   input wire logic [7:0] tablePointerLow,
   input wire logic [7:0] table_pointer_high,
   input wire logic [7:0] table_high_latch,
   input wire logic [11:0] progAddr,
   input wire logic progRead,
   input wire logic [15:0] progData,
   input wire logic destWrite,
   input wire logic [7:0] destWriteAddr,
   input wire logic [7:0] destWriteData,
   input wire logic busy
);
   localparam logic [7:0] HIGH_MASK = 8'(16'h00ff >> (8 - HIGH_BITS));
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence rd; (tableReadOp || table_read_extended_op) && !busy; endsequence
   sequence fetchStep; busy && !destWrite; endsequence
   sequence doneStep; !busy && destWrite; endsequence
   addr_form_a: assert property (progAddr == {table_pointer_high[3:0], tablePointerLow})
      else $error("bad address");
   two_cycle_a: assert property (rd |=> fetchStep ##1 doneStep)
      else $error("bad timing");
   low_byte_a: assert property (rd ##1 1 |=> destWriteData == $past(progData[7:0]))
      else $error("bad low byte");
   latch_load_a: assert property (rd ##1 1 |=>
      table_high_latch == ($past(progData[15:8]) & HIGH_MASK))
      else $error("bad latch load");
   dest_addr_a: assert property (rd |-> ##2 destWriteAddr == $past(destAddr, 2))
      else $error("bad destination");
   high_zero_a: assert property (table_pointer_high[7:4] == 4'h0)
      else $error("bad pointer bits");
   ptr_hold_a: assert property (!ptrLowWrite |=> $stable(tablePointerLow))
      else $error("pointer moved");
   sw_latch_a: assert property (latchWrite && !busy |=> table_high_latch == $past(wrData))
      else $error("bad latch write");
   ptr_high_hold_a: assert property (!table_pointer_highWrite |=>
      $stable(table_pointer_high))
      else $error("high pointer moved");
   dest_pulse_a: assert property (destWrite |=> !destWrite)
      else $error("long destination write");
   busy_refuse_a: assert property (busy |-> !progRead)
      else $error("request taken while busy");
endmodule

// *** program_memory_table_read_test.sv ***
/* bench for the table-read unit with a behavioural program memory.
   inputs change on falling edges; memory answers one cycle after the address */
`timescale 1ns/1ps
module program_memory_table_read_test;
   logic core_clk = 0, rst_b = 0, tableReadOp = 0, table_read_extended_op = 0, ptrLowWrite = 0;
   logic table_pointer_highWrite = 0, latchWrite = 0, destWrite, busy, progRead;
   logic [7:0] destAddr = 0, wrData = 0, tablePointerLow, table_pointer_high, table_high_latch;
   logic [7:0] destWriteAddr, destWriteData;
   logic [11:0] progAddr;
   logic [15:0] progData = 0;
   int n_errors = 0, comparisons = 0, cyc = 0;
   ptr_table_read u_ptr_table_read (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .tableReadOp(tableReadOp),
      .table_read_extended_op(table_read_extended_op),
      .destAddr(destAddr),
      .ptrLowWrite(ptrLowWrite),
      .table_pointer_highWrite(table_pointer_highWrite),
      .latchWrite(latchWrite),
      .wrData(wrData),
      .tablePointerLow(tablePointerLow),
      .table_pointer_high(table_pointer_high),
      .table_high_latch(table_high_latch),
      .progAddr(progAddr),
      .progRead(progRead),
      .progData(progData),
      .destWrite(destWrite),
      .destWriteAddr(destWriteAddr),
      .destWriteData(destWriteData),
      .busy(busy)
   );
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      progData <= progRead ? {progAddr[11:4], progAddr[7:0] ^ 8'h5a} : ~progData;
      cyc <= cyc + 1;
      if (cyc == 500) begin
         n_errors++;
         wrap_up;
      end
   end
   task chk(input logic [15:0] s, e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t: got %h want %h", $time, s, e);
      end
   endtask
   task wrap_up;
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task wr(input logic [2:0] k, input logic [7:0] v);
      @(negedge core_clk);
      {latchWrite, table_pointer_highWrite, ptrLowWrite} = k;
      wrData = v;
      @(negedge core_clk);
      {latchWrite, table_pointer_highWrite, ptrLowWrite} = 3'h0;
   endtask
   task rd(input logic x, input logic [7:0] d, input logic [11:0] a);
      @(negedge core_clk);
      {table_read_extended_op, tableReadOp} = {x, !x};
      destAddr = d;
      #10;
      chk({progRead, 3'h0, progAddr}, {1'b1, 3'h0, a});
      @(negedge core_clk);
      {table_read_extended_op, tableReadOp} = 2'h0;
      chk(busy, 16'h1);
      @(negedge core_clk);
      chk({destWrite, destWriteAddr}, {1'b1, d});
      chk({table_high_latch, destWriteData}, {a[11:4], a[7:0] ^ 8'h5a});
      chk({table_pointer_high, tablePointerLow}, {4'h0, a});
   endtask
   task t_read;
      wr(3'h2, 8'hff); // upper pointer bits stay zero
      wr(3'h1, 8'h06);
      rd(1'b0, 8'h11, 12'hf06);
      wr(3'h1, 8'h05);
      rd(1'b1, 8'h92, 12'hf05);
      $display("read test done");
   endtask
   task t_refuse;
      @(negedge core_clk);
      tableReadOp = 1'b1;
      destAddr = 8'h44;
      @(negedge core_clk);
      latchWrite = 1'b1;
      wrData = 8'h99;
      chk(progRead, 16'h0);
      @(negedge core_clk);
      {tableReadOp, latchWrite} = 2'h0;
      chk({destWrite, destWriteAddr}, {1'b1, 8'h44});
      chk(table_high_latch, 16'hf0);
      @(negedge core_clk);
      chk({destWrite, busy}, 16'h0);
      $display("refuse test done");
   endtask
   task t_latch;
      logic [7:0] saved;
      wr(3'h4, 8'h3c);
      chk(table_high_latch, 16'h3c);
      // interrupt-style save, one read at a time, then restore
      saved = table_high_latch;
      rd(1'b0, 8'h20, 12'hf05);
      wr(3'h4, saved);
      chk(table_high_latch, {8'h00, saved});
      $display("latch test done");
   endtask
   task t_reset;
      @(negedge core_clk);
      rst_b = 1'b0;
      @(negedge core_clk);
      chk({table_pointer_high, tablePointerLow}, {ptr_pkg::PTR_HIGH_RST, ptr_pkg::PTR_LOW_RST});
      chk({table_high_latch, destWriteData}, {ptr_pkg::LATCH_RST, 8'h00});
      chk({busy, destWrite, progRead, destWriteAddr}, 16'h0000);
      rst_b = 1'b1;
      rd(1'b1, 8'h33, 12'h000);
      $display("reset test done");
   endtask
   initial begin
      repeat (10) @(negedge core_clk);
      rst_b = 1;
      t_read;
      t_refuse;
      t_latch;
      t_reset;
      wrap_up;
   end
endmodule
bind ptr_table_read ptr_table_read_chk #(
   .HIGH_BITS(HIGH_BITS)
) u_ptr_table_read_chk (
   .core_clk(core_clk),
   .rst_b(rst_b),
   .tableReadOp(tableReadOp),
   .table_read_extended_op(table_read_extended_op),
   .destAddr(destAddr),
   .ptrLowWrite(ptrLowWrite),
   .table_pointer_highWrite(table_pointer_highWrite),
   .latchWrite(latchWrite),
   .wrData(wrData),
   .tablePointerLow(tablePointerLow),
   .table_pointer_high(table_pointer_high),
   .table_high_latch(table_high_latch),
   .progAddr(progAddr),
   .progRead(progRead),
   .progData(progData),
   .destWrite(destWrite),
   .destWriteAddr(destWriteAddr),
   .destWriteData(destWriteData),
   .busy(busy)
);
